// [hdl/e1ca_pkg.sv]
// Purpose: constants shared by the cas multiframe and alarm integration logic
// Assumes: 256-bit e1 frames, timeslot 16 bit 1 sent first
// Notes:   interval frame counts derive from frame and interval figures
package e1ca_pkg;

	// =========================================================
	// frame geometry
	localparam logic [7:0] TS16_FIRST_BIT   = 8'h80;
	localparam logic [7:0] TS16_LAST_BIT    = 8'h87;
	localparam int         RMA_BIT_INDEX    = 2;
	localparam logic [3:0] MAS_PATTERN      = 4'h0;
	localparam logic [3:0] MF_LAST_FRAME    = 4'hF;

	// =========================================================
	// multiframe search and loss
	localparam logic [3:0] MF_SEARCH_FRAMES = 4'hF;
	localparam logic [1:0] MF_ERR_LIMIT     = 2'h2;
	localparam logic [5:0] ZERO_RUN_ONE_MF  = 6'h10;
	localparam logic [5:0] ZERO_RUN_TWO_MF  = 6'h20;
	localparam logic [1:0] RMA_DEBOUNCE     = 2'h2;

	// =========================================================
	// integration interval
	localparam int         INTERVAL_MS      = 4;
	localparam int         FRAME_US         = 125;
	localparam int         INTERVAL_FRAMES  = INTERVAL_MS * 1000 / FRAME_US;
	localparam logic [4:0] INTERVAL_LAST    = 5'(INTERVAL_FRAMES - 1);
	localparam logic [4:0] AIS_PRESENT_MIN  = 5'h0D;
	localparam logic [4:0] AIS_EVENT_MAX    = 5'h10;
	localparam logic [4:0] AIS_ALARM_LIMIT  = 5'h19;
	localparam logic [4:0] T16_ALARM_LIMIT  = 5'h16;
	localparam logic [4:0] RED_ALARM_LIMIT  = 5'h19;

	// =========================================================
	// unframed all-ones window
	localparam logic [8:0] ONES_WINDOW_LAST = 9'h1FF;
	localparam logic [1:0] ONES_ZERO_MIN    = 2'h3;

	typedef enum logic {MF_SEARCH, MF_ALIGNED} e1ca_mf_state_t;

endpackage

// [hdl/e1ca_ifs.sv]
// Purpose: carriers between the top and its integrator and detector
// Assumes: one clock domain
// Notes:   ce travels with each carrier so submodules freeze too
`timescale 1ns/1ps

interface e1ca_integ_if;
	logic ce;
	logic tick;
	logic present;
	logic alarm;
	modport ctrl  (output ce, output tick, output present, input alarm);
	modport integ (input ce, input tick, input present, output alarm);
endinterface

interface e1ca_ones_if;
	logic ce;
	logic bit_valid;
	logic bit_data;
	logic frame_lost;
	logic event_pulse;
	logic detect;
	modport ctrl (output ce, output bit_valid, output bit_data, output frame_lost,
	              input event_pulse, input detect);
	modport det  (input ce, input bit_valid, input bit_data, input frame_lost,
	              output event_pulse, output detect);
endinterface

// [hdl/e1ca_integrator.sv]
// Purpose: up/down interval counter with alarm hysteresis
// Assumes: tick is one cycle per interval, present valid with it
// Notes:   counter saturates at the limit so clearing takes as long as raising
`timescale 1ns/1ps

module e1ca_integrator #(
	parameter logic [4:0] LIMIT = 5'h19
) (
	input wire logic   clock,
	input wire logic   rst_n,
	e1ca_integ_if.integ port_if
);

	logic [4:0] count_r;
	logic       alarm_r;

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			count_r <= 5'h00;
		else if (port_if.ce && port_if.tick)
		begin
			if (port_if.present && count_r != LIMIT)
				count_r <= count_r + 5'h01;
			else if (!port_if.present && count_r != 5'h00)
				count_r <= count_r - 5'h01;
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			alarm_r <= 1'b0;
		else if (port_if.ce)
		begin
			if (count_r == LIMIT)
				alarm_r <= 1'b1;
			else if (count_r == 5'h00)
				alarm_r <= 1'b0;
		end
	end

	assign port_if.alarm = alarm_r;

endmodule

// [hdl/e1ca_ones_detect.sv]
// Purpose: unframed all-ones detection over fixed 512-bit windows
// Assumes: bit_valid marks each received line bit
// Notes:   windows do not overlap, giving 16 verdicts per 4 ms
`timescale 1ns/1ps

module e1ca_ones_detect (
	input wire logic  clock,
	input wire logic  rst_n,
	e1ca_ones_if.det  port_if
);

	logic [8:0] bit_cnt_r;
	logic [1:0] zero_cnt_r;
	logic [1:0] zero_cnt_nxt;
	logic       event_r;
	logic       detect_r;

	always_comb
	begin
		zero_cnt_nxt = zero_cnt_r;
		if (!port_if.bit_data && zero_cnt_r != e1ca_pkg::ONES_ZERO_MIN)
			zero_cnt_nxt = zero_cnt_r + 2'h1;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bit_cnt_r  <= 9'h000;
			zero_cnt_r <= 2'h0;
			event_r    <= 1'b0;
		end
		else if (port_if.ce)
		begin
			event_r <= 1'b0;
			if (port_if.bit_valid)
			begin
				bit_cnt_r <= bit_cnt_r + 9'h001;
				if (bit_cnt_r == e1ca_pkg::ONES_WINDOW_LAST)
				begin
					event_r    <= (zero_cnt_nxt != e1ca_pkg::ONES_ZERO_MIN);
					zero_cnt_r <= 2'h0;
				end
				else
					zero_cnt_r <= zero_cnt_nxt;
			end
		end
	end

	// level drops on a window with 3 or more zeros or once framing is regained
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			detect_r <= 1'b0;
		else if (port_if.ce)
		begin
			if (!port_if.frame_lost)
				detect_r <= 1'b0;
			else if (port_if.bit_valid && bit_cnt_r == e1ca_pkg::ONES_WINDOW_LAST)
				detect_r <= (zero_cnt_nxt != e1ca_pkg::ONES_ZERO_MIN);
		end
	end

	assign port_if.event_pulse = event_r;
	assign port_if.detect      = detect_r;

endmodule

// [hdl/e1ca_top.sv]
// Purpose: cas multiframe find/monitor and alarm integration for e1 receive
// Assumes: frame aligner logic on this clock supplies bit_valid, frame_start, frame_lost
// Notes:   all state freezes while clk_en is low
//
// Overview of operation
// - search after framing; 15 nonpattern frames then pattern
// - alternate search: nonzero bits then pattern
// - multiframe lost flag low while aligned
// - check every alignment nibble, flag errors
// - report debounced remote multiframe alarm bit
// - slot 16 all ones twice, unaligned
// - two consecutive pattern errors lose alignment
// - all-zero slot 16 for 1/2 multiframes
// - frame loss drops multiframe alignment at once
// - ais and red alarms raise and clear after about 100 ms, slot 16 ais after about 88 ms
// - fewer than 3 zeros per 512 bits
// - 13 of 16 events marks ais interval
// - ais counter declares 25, clears 0
// - slot 16 ais counter declares 22, clears 0
// - any frame loss marks interval out-of-frame
// - red counter declares 25, clears 0
// - remote alarm set after 2 consecutive ones
// - event and status change indications for interrupts
`timescale 1ns/1ps

module e1ca_top (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       clk_en,
	input  wire logic       bit_valid,
	input  wire logic       rx_data,
	input  wire logic       frame_start,
	input  wire logic       frame_lost,
	input  wire logic       mf_algo_sel,
	input  wire logic       zero_mf_sel,
	output logic            cas_multiframe_lost,
	output logic [3:0]      cas_frame_number,
	output logic            multiframe_pattern_error_event,
	output logic            remote_multiframe_alarm,
	output logic            remote_multiframe_alarm_event,
	output logic            slot16_all_ones_detect,
	output logic            all_ones_detect,
	output logic            all_ones_event,
	output logic            in_frame_interval,
	output logic            ais_alarm,
	output logic            slot16_ais_alarm,
	output logic            red_alarm,
	output logic            status_change_event
);

	// =========================================================
	// frame position and timeslot 16 capture
	logic [7:0] bit_pos_r;
	logic [7:0] pos_now;
	logic [6:0] shift_r;
	logic [7:0] slot_byte_r;
	logic       byte_done_r;
	logic       frame_tick;

	assign pos_now    = frame_start ? 8'h00 : bit_pos_r + 8'h01;
	assign frame_tick = clk_en && bit_valid && frame_start;

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bit_pos_r <= 8'hFF;
			shift_r   <= 7'h00;
		end
		else if (clk_en && bit_valid)
		begin
			bit_pos_r <= pos_now;
			if (pos_now >= e1ca_pkg::TS16_FIRST_BIT && pos_now < e1ca_pkg::TS16_LAST_BIT)
				shift_r <= {shift_r[5:0], rx_data};
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			slot_byte_r <= 8'h00;
			byte_done_r <= 1'b0;
		end
		else if (clk_en)
		begin
			byte_done_r <= 1'b0;
			if (bit_valid && pos_now == e1ca_pkg::TS16_LAST_BIT)
			begin
				slot_byte_r <= {shift_r, rx_data};
				byte_done_r <= 1'b1;
			end
		end
	end

	// =========================================================
	// byte classification
	logic byte_ok;
	logic mas_ok;
	logic all_zero;
	logic all_one;

	// a frame-loss cycle overrides any byte that completes with it
	assign byte_ok  = clk_en && byte_done_r && !frame_lost;
	assign mas_ok   = (slot_byte_r[7:4] == e1ca_pkg::MAS_PATTERN);
	assign all_zero = (slot_byte_r == 8'h00);
	assign all_one  = (slot_byte_r == 8'hFF);

	// =========================================================
	// multiframe state machine
	e1ca_pkg::e1ca_mf_state_t st_r;
	e1ca_pkg::e1ca_mf_state_t st_nxt;
	logic [3:0] nz_run_r;
	logic       prev_nz_r;
	logic [3:0] mf_frame_r;
	logic [1:0] err_run_r;
	logic [5:0] zero_run_r;
	logic [5:0] zero_limit;
	logic       expect_mas;
	logic       found;
	logic       pattern_err;
	logic       err_loss;
	logic       zero_loss;

	assign expect_mas  = (mf_frame_r == e1ca_pkg::MF_LAST_FRAME);
	assign zero_limit  = zero_mf_sel ? e1ca_pkg::ZERO_RUN_TWO_MF : e1ca_pkg::ZERO_RUN_ONE_MF;
	assign found       = mas_ok && (mf_algo_sel ? prev_nz_r : (nz_run_r == e1ca_pkg::MF_SEARCH_FRAMES));
	assign pattern_err = (st_r == e1ca_pkg::MF_ALIGNED) && byte_ok && expect_mas && !mas_ok;
	assign err_loss    = pattern_err && (err_run_r == e1ca_pkg::MF_ERR_LIMIT - 2'h1);
	assign zero_loss   = byte_ok && all_zero && (zero_run_r == zero_limit - 6'h01);

	always_comb
	begin
		st_nxt = st_r;
		unique case (st_r)
			e1ca_pkg::MF_SEARCH:
			begin
				if (byte_ok && found)
					st_nxt = e1ca_pkg::MF_ALIGNED;
			end
			e1ca_pkg::MF_ALIGNED:
			begin
				if (err_loss || zero_loss)
					st_nxt = e1ca_pkg::MF_SEARCH;
			end
		endcase
		if (frame_lost)
			st_nxt = e1ca_pkg::MF_SEARCH;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			st_r <= e1ca_pkg::MF_SEARCH;
		else if (clk_en)
			st_r <= st_nxt;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			cas_multiframe_lost <= 1'b1;
		else if (clk_en)
			cas_multiframe_lost <= (st_nxt == e1ca_pkg::MF_SEARCH);
	end

	// search history; cleared while frame alignment is absent
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			nz_run_r  <= 4'h0;
			prev_nz_r <= 1'b0;
		end
		else if (clk_en)
		begin
			if (frame_lost || st_r == e1ca_pkg::MF_ALIGNED)
			begin
				nz_run_r  <= 4'h0;
				prev_nz_r <= 1'b0;
			end
			else if (byte_ok)
			begin
				prev_nz_r <= !mas_ok;
				if (mas_ok)
					nz_run_r <= 4'h0;
				else if (nz_run_r != e1ca_pkg::MF_SEARCH_FRAMES)
					nz_run_r <= nz_run_r + 4'h1;
			end
		end
	end

	// frame index inside the multiframe; the aligning byte is frame 0
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			mf_frame_r <= 4'h0;
		else if (clk_en && byte_ok)
		begin
			if (st_r == e1ca_pkg::MF_SEARCH)
				mf_frame_r <= 4'h0;
			else
				mf_frame_r <= mf_frame_r + 4'h1;
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			cas_frame_number <= 4'h0;
		else if (clk_en)
			cas_frame_number <= mf_frame_r;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			err_run_r <= 2'h0;
		else if (clk_en)
		begin
			if (st_r == e1ca_pkg::MF_SEARCH || err_loss)
				err_run_r <= 2'h0;
			else if (pattern_err)
				err_run_r <= err_run_r + 2'h1;
			else if (byte_ok && expect_mas)
				err_run_r <= 2'h0;
		end
	end

	// runs in search too, so a zero run that straddles alignment still counts
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			zero_run_r <= 6'h00;
		else if (clk_en)
		begin
			if (frame_lost || zero_loss)
				zero_run_r <= 6'h00;
			else if (byte_ok)
				zero_run_r <= all_zero ? zero_run_r + 6'h01 : 6'h00;
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			multiframe_pattern_error_event <= 1'b0;
		else if (clk_en)
			multiframe_pattern_error_event <= pattern_err;
	end

	// =========================================================
	// remote multiframe alarm debounce
	logic [1:0] rma_run_r;
	logic       rma_sample;
	logic       rma_set;

	assign rma_sample = (st_r == e1ca_pkg::MF_ALIGNED) && byte_ok && expect_mas && mas_ok;
	assign rma_set    = rma_sample && slot_byte_r[e1ca_pkg::RMA_BIT_INDEX]
	                    && (rma_run_r == e1ca_pkg::RMA_DEBOUNCE - 2'h1);

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rma_run_r               <= 2'h0;
			remote_multiframe_alarm <= 1'b0;
		end
		else if (clk_en)
		begin
			if (st_nxt == e1ca_pkg::MF_SEARCH)
			begin
				rma_run_r               <= 2'h0;
				remote_multiframe_alarm <= 1'b0;
			end
			else if (rma_sample)
			begin
				if (!slot_byte_r[e1ca_pkg::RMA_BIT_INDEX])
				begin
					rma_run_r               <= 2'h0;
					remote_multiframe_alarm <= 1'b0;
				end
				else if (rma_run_r != e1ca_pkg::RMA_DEBOUNCE)
					rma_run_r <= rma_run_r + 2'h1;
				if (rma_set)
					remote_multiframe_alarm <= 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			remote_multiframe_alarm_event <= 1'b0;
		else if (clk_en)
			remote_multiframe_alarm_event <= rma_set && !remote_multiframe_alarm;
	end

	// =========================================================
	// timeslot 16 ais detection
	logic ones_prev_r;

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ones_prev_r            <= 1'b0;
			slot16_all_ones_detect <= 1'b0;
		end
		else if (clk_en)
		begin
			if (st_nxt == e1ca_pkg::MF_ALIGNED || frame_lost)
			begin
				ones_prev_r            <= 1'b0;
				slot16_all_ones_detect <= 1'b0;
			end
			else if (byte_ok)
			begin
				ones_prev_r            <= all_one;
				slot16_all_ones_detect <= all_one && ones_prev_r;
			end
		end
	end

	// =========================================================
	// unframed all-ones detector
	e1ca_ones_if ones_if ();

	assign ones_if.ce         = clk_en;
	assign ones_if.bit_valid  = bit_valid;
	assign ones_if.bit_data   = rx_data;
	assign ones_if.frame_lost = frame_lost;

	e1ca_ones_detect u_ones (
		.clock   (clock),
		.rst_n   (rst_n),
		.port_if (ones_if.det)
	);

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			all_ones_detect <= 1'b0;
			all_ones_event  <= 1'b0;
		end
		else if (clk_en)
		begin
			all_ones_detect <= ones_if.detect;
			all_ones_event  <= ones_if.event_pulse;
		end
	end

	// =========================================================
	// 4 ms interval accumulation
	logic [4:0] frm_cnt_r;
	logic [4:0] ais_evt_r;
	logic       oof_seen_r;
	logic       t16_seen_r;
	logic       interval_end;
	logic       tick_r;
	logic       ais_present_r;
	logic       t16_present_r;
	logic       oof_present_r;

	assign interval_end = frame_tick && (frm_cnt_r == e1ca_pkg::INTERVAL_LAST);

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			frm_cnt_r <= 5'h00;
		else if (frame_tick)
			frm_cnt_r <= frm_cnt_r + 5'h01;
	end

	// an event in the closing cycle opens the next interval, not lost
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ais_evt_r  <= 5'h00;
			oof_seen_r <= 1'b0;
			t16_seen_r <= 1'b0;
		end
		else if (clk_en)
		begin
			if (interval_end)
			begin
				ais_evt_r  <= {4'h0, ones_if.event_pulse};
				oof_seen_r <= frame_lost;
				t16_seen_r <= slot16_all_ones_detect;
			end
			else
			begin
				if (ones_if.event_pulse && ais_evt_r != e1ca_pkg::AIS_EVENT_MAX)
					ais_evt_r <= ais_evt_r + 5'h01;
				oof_seen_r <= oof_seen_r || frame_lost;
				t16_seen_r <= t16_seen_r || slot16_all_ones_detect;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tick_r            <= 1'b0;
			ais_present_r     <= 1'b0;
			t16_present_r     <= 1'b0;
			oof_present_r     <= 1'b0;
			in_frame_interval <= 1'b0;
		end
		else if (clk_en)
		begin
			tick_r            <= interval_end;
			in_frame_interval <= interval_end && !(oof_seen_r || frame_lost);
			if (interval_end)
			begin
				ais_present_r <= (ais_evt_r >= e1ca_pkg::AIS_PRESENT_MIN);
				t16_present_r <= t16_seen_r || slot16_all_ones_detect;
				oof_present_r <= oof_seen_r || frame_lost;
			end
		end
	end

	// =========================================================
	// alarm integrators
	e1ca_integ_if ais_if ();
	e1ca_integ_if t16_if ();
	e1ca_integ_if red_if ();

	assign ais_if.ce      = clk_en;
	assign ais_if.tick    = tick_r;
	assign ais_if.present = ais_present_r;
	assign t16_if.ce      = clk_en;
	assign t16_if.tick    = tick_r;
	assign t16_if.present = t16_present_r;
	assign red_if.ce      = clk_en;
	assign red_if.tick    = tick_r;
	assign red_if.present = oof_present_r;

	e1ca_integrator #(.LIMIT(e1ca_pkg::AIS_ALARM_LIMIT)) u_ais_integ (
		.clock   (clock),
		.rst_n   (rst_n),
		.port_if (ais_if.integ)
	);

	e1ca_integrator #(.LIMIT(e1ca_pkg::T16_ALARM_LIMIT)) u_t16_integ (
		.clock   (clock),
		.rst_n   (rst_n),
		.port_if (t16_if.integ)
	);

	e1ca_integrator #(.LIMIT(e1ca_pkg::RED_ALARM_LIMIT)) u_red_integ (
		.clock   (clock),
		.rst_n   (rst_n),
		.port_if (red_if.integ)
	);

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ais_alarm        <= 1'b0;
			slot16_ais_alarm <= 1'b0;
			red_alarm        <= 1'b0;
		end
		else if (clk_en)
		begin
			ais_alarm        <= ais_if.alarm;
			slot16_ais_alarm <= t16_if.alarm;
			red_alarm        <= red_if.alarm;
		end
	end

	// =========================================================
	// status change indication
	logic [3:0] status_prev_r;
	logic [3:0] status_now;

	assign status_now = {cas_multiframe_lost, ais_alarm, slot16_ais_alarm, red_alarm};

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			status_prev_r       <= 4'h8;
			status_change_event <= 1'b0;
		end
		else if (clk_en)
		begin
			status_prev_r       <= status_now;
			status_change_event <= (status_now != status_prev_r);
		end
	end

endmodule

// [tb/e1ca_src_model.sv]
// Purpose: upstream source of framed e1 bits for the cas block
// Assumes: one bit every second clock, ts16 byte latched before bit 128
// Notes:   rx_data toggles between strobes so stale values never pass
`timescale 1ns/1ps

module e1ca_src_model (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic [7:0] ts16_byte,
	input  wire logic       fill_ones,
	output logic            bit_valid,
	output logic            rx_data,
	output logic            frame_start
);
	logic [7:0] pos_r;
	logic [7:0] byte_r;
	logic       ph_r;

	// ==========================================
	// bit stream
	// 256-bit frames
	always @(negedge clock or negedge rst_n)
		if (!rst_n)
		begin
			ph_r <= 1'b0;
			pos_r <= 8'h00;
			byte_r <= 8'h00;
			bit_valid <= 1'b0;
			rx_data <= 1'b0;
			frame_start <= 1'b0;
		end
		else
		begin
			ph_r <= !ph_r;
			bit_valid <= ph_r;
			frame_start <= ph_r && pos_r == 8'h00;
			if (!ph_r)
				rx_data <= !rx_data;
			else
			begin
				pos_r <= pos_r + 8'h01;
				if (pos_r == 8'h7F)
					byte_r <= ts16_byte;
				rx_data <= (pos_r[7:3] == 5'h10) ? byte_r[3'h7 - pos_r[2:0]] : (fill_ones | pos_r[0]);
			end
		end
endmodule

// [tb/e1ca_asserts.sv]
// Purpose: port-level checks of the cas multiframe and alarm block
// Assumes: bit strobes at least two clocks apart
// Notes:   alarm rise is bounded below by frames seen since reset
`timescale 1ns/1ps

module e1ca_asserts (
	input wire logic       clock,
	input wire logic       rst_n,
	input wire logic       clk_en,
	input wire logic       frame_start,
	input wire logic       frame_lost,
	input wire logic       cas_multiframe_lost,
	input wire logic [3:0] cas_frame_number,
	input wire logic       multiframe_pattern_error_event,
	input wire logic       remote_multiframe_alarm,
	input wire logic       remote_multiframe_alarm_event,
	input wire logic       slot16_all_ones_detect,
	input wire logic       all_ones_event,
	input wire logic       ais_alarm,
	input wire logic       slot16_ais_alarm,
	input wire logic       red_alarm,
	input wire logic       status_change_event
);
	logic [9:0] frames_r;

	// ==========================================
	// frames since reset, saturating
	always_ff @(posedge clock or negedge rst_n)
		if (!rst_n)
			frames_r <= 10'h000;
		else if (frame_start && frames_r != 10'h3FF)
			frames_r <= frames_r + 10'h001;

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	// ==========================================
	// properties
	property p_loss_forces_search;
		frame_lost && clk_en |=> cas_multiframe_lost;
	endproperty
	property p_t16_unaligned;
		$rose(slot16_all_ones_detect) |-> cas_multiframe_lost;
	endproperty
	property p_err_aligned;
		multiframe_pattern_error_event |-> !$past(cas_multiframe_lost);
	endproperty
	property p_frame_step;
		$changed(cas_frame_number) && !cas_multiframe_lost && !$past(cas_multiframe_lost)
			&& !$past(cas_multiframe_lost, 2) |-> cas_frame_number == $past(cas_frame_number) + 4'h1;
	endproperty
	property p_rma_event;
		remote_multiframe_alarm_event |-> ##[0:1] remote_multiframe_alarm;
	endproperty
	property p_status_change;
		$changed(cas_multiframe_lost) |-> ##[0:2] status_change_event;
	endproperty
	property p_ais_slow;
		$rose(ais_alarm) |-> frames_r >= 10'h320;
	endproperty
	property p_t16_slow;
		$rose(slot16_ais_alarm) |-> frames_r >= 10'h2C0;
	endproperty
	property p_red_slow;
		$rose(red_alarm) |-> frames_r >= 10'h320;
	endproperty
	property p_ais_event_pulse;
		all_ones_event |=> !all_ones_event [*8];
	endproperty

	a_loss_forces_search: assert property (p_loss_forces_search) else $error("no search on frame loss");
	a_t16_unaligned: assert property (p_t16_unaligned) else $error("slot16 detect while aligned");
	a_err_aligned: assert property (p_err_aligned) else $error("pattern error while unaligned");
	a_frame_step: assert property (p_frame_step) else $error("frame number skipped");
	a_rma_event: assert property (p_rma_event) else $error("alarm event without alarm");
	a_status_change: assert property (p_status_change) else $error("no status change event");
	a_ais_slow: assert property (p_ais_slow) else $error("ais alarm too early");
	a_t16_slow: assert property (p_t16_slow) else $error("slot16 alarm too early");
	a_red_slow: assert property (p_red_slow) else $error("red alarm too early");
	a_ais_event_pulse: assert property (p_ais_event_pulse) else $error("ais events too close");

	c_align: cover property ($fell(cas_multiframe_lost));
	c_rma: cover property ($rose(remote_multiframe_alarm));
	c_ais: cover property (all_ones_event);
endmodule

bind e1ca_top e1ca_asserts u_asserts (.*);

// [tb/tb_top.sv]
// Purpose: self-checking bench for the cas multiframe and alarm block
// Assumes: source model sends one bit every second clock
// Notes:   integrated alarms cannot reach their limits in this run length
`timescale 1ns/1ps
`define CHK(a, b) \
	begin \
		samples_checked++; \
		if ((a) !== (b)) \
		begin \
			bad_count++; \
			$display("[ERR] %0t got %0h want %0h", $time, (a), (b)); \
		end \
	end

module tb_top;
	logic        clock       = 1'b0;
	logic        rst_n       = 1'b0;
	logic        clk_en      = 1'b1;
	logic        frame_lost  = 1'b0;
	logic        mf_algo_sel = 1'b1;
	logic        zero_mf_sel = 1'b0;
	logic        fill_ones   = 1'b0;
	logic [7:0]  ts16_byte   = 8'h11;
	logic [16:0] lfsr        = 17'h10295;
	logic        bit_valid, rx_data, frame_start, cas_multiframe_lost, multiframe_pattern_error_event;
	logic        remote_multiframe_alarm, remote_multiframe_alarm_event, slot16_all_ones_detect;
	logic        all_ones_detect, all_ones_event, in_frame_interval, ais_alarm, slot16_ais_alarm;
	logic        red_alarm, status_change_event;
	logic [3:0]  cas_frame_number;
	int          bad_count, samples_checked, n_err, n_rma, n_aev, n_inf, n_st;

	always #4 clock = ~clock;

	e1ca_src_model u_src (.*);
	e1ca_top DUT (.*);

	// tally mid-cycle, where each one-cycle pulse has settled
	always @(negedge clock)
	begin
		n_err <= n_err + multiframe_pattern_error_event;
		n_rma <= n_rma + remote_multiframe_alarm_event;
		n_aev <= n_aev + all_ones_event;
		n_inf <= n_inf + in_frame_interval;
		n_st <= n_st + status_change_event;
	end

	function automatic logic [16:0] lfsr_next(input logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction

	// ==========================================
	// frame level drivers
	// blocks until the frame carrying b has ended
	task automatic send(input logic [7:0] b);
		@(negedge clock);
		ts16_byte = b;
		@(posedge frame_start);
	endtask
	// nonzero nibble, never all ones
	task automatic nz();
		lfsr = lfsr_next(lfsr);
		send({lfsr[7:4] | 4'h1, lfsr[3:0] & 4'h7});
	endtask
	task automatic mf(input logic [7:0] b0);
		send(b0);
		repeat (15) nz();
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial
	begin
		#1200000;
		bad_count++;
		report_and_stop();
	end

	initial
	begin
		repeat (6) @(posedge clock);
		@(negedge clock);
		rst_n = 1'b1;
		`CHK(cas_multiframe_lost, 1'b1)
		`CHK({remote_multiframe_alarm, slot16_all_ones_detect, all_ones_detect, red_alarm}, 4'h0)
		// start on a frame boundary so the first byte is not overwritten
		@(posedge frame_start);
		nz();
		send(8'h0B);
		`CHK(cas_multiframe_lost, 1'b0)
		`CHK(cas_frame_number, 4'h0)
		repeat (15) nz();
		`CHK(cas_frame_number, 4'hF)
		mf(8'h0F);
		`CHK(remote_multiframe_alarm, 1'b0)
		mf(8'h0F);
		`CHK(remote_multiframe_alarm, 1'b1)
		mf(8'h8B);
		`CHK(n_err, 1)
		`CHK(cas_multiframe_lost, 1'b0)
		mf(8'h0B);
		`CHK(remote_multiframe_alarm, 1'b0)
		`CHK(n_rma, 1)
		mf(8'h4B);
		mf(8'h8B);
		`CHK(cas_multiframe_lost, 1'b1)
		`CHK(n_err, 3)
		`CHK(n_st, 2)
		nz();
		send(8'h0B);
		@(negedge clock);
		frame_lost = 1'b1;
		mf_algo_sel = 1'b0;
		@(negedge clock);
		`CHK(cas_multiframe_lost, 1'b1)
		frame_lost = 1'b0;
		repeat (14) nz();
		send(8'h0B);
		`CHK(cas_multiframe_lost, 1'b1)
		repeat (15) nz();
		send(8'h0B);
		`CHK(cas_multiframe_lost, 1'b0)
		repeat (15) send(8'h00);
		`CHK(cas_multiframe_lost, 1'b0)
		send(8'h00);
		`CHK(cas_multiframe_lost, 1'b1)
		mf_algo_sel = 1'b1;
		zero_mf_sel = 1'b1;
		nz();
		send(8'h0B);
		repeat (31) send(8'h00);
		`CHK(cas_multiframe_lost, 1'b0)
		send(8'h00);
		`CHK(cas_multiframe_lost, 1'b1)
		send(8'hFF);
		`CHK(slot16_all_ones_detect, 1'b0)
		send(8'hFF);
		`CHK(slot16_all_ones_detect, 1'b1)
		`CHK(n_aev, 0)
		@(negedge clock);
		frame_lost = 1'b1;
		fill_ones = 1'b1;
		repeat (3) send(8'hFF);
		`CHK(all_ones_detect, 1'b1)
		`CHK(n_aev >= 1, 1'b1)
		`CHK(n_inf > 0, 1'b1)
		`CHK({ais_alarm, slot16_ais_alarm, red_alarm}, 3'h0)
		// frozen block must keep its detect level although framing returns
		repeat (4) @(negedge clock);
		clk_en = 1'b0;
		frame_lost = 1'b0;
		repeat (600) @(negedge clock);
		`CHK({all_ones_detect, cas_multiframe_lost}, 2'h3)
		clk_en = 1'b1;
		repeat (3) @(negedge clock);
		`CHK(all_ones_detect, 1'b0)
		report_and_stop();
	end
endmodule
